/* File: pkg/io_decode_pkg.sv */
/*
 * Constants for the I/O address decoder: register addresses, reset values,
 * decode patterns, mask field positions and the slot count.
 * Assumes it is compiled before every design file that names it.
 */
package io_decode_pkg;

   // ****************************************************************
   // Register addresses (full 16-bit I/O addresses)
   // ****************************************************************
   localparam logic [15:0] ADDR_CS0_BASE_LOW = 16'h0C02;
   localparam logic [15:0] ADDR_CS0_BASE_HIGH = 16'h0C03;
   localparam logic [15:0] ADDR_CS1_BASE_LOW = 16'h0C04;
   localparam logic [15:0] ADDR_CS1_BASE_HIGH = 16'h0C05;
   localparam logic [15:0] ADDR_CS0_MASK_CONTROL = 16'h0C06;
   localparam logic [15:0] ADDR_CS1_MASK_CONTROL = 16'h0C07;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_CS0_BASE_LOW = 8'h00;
   localparam logic [7:0] RST_CS0_BASE_HIGH = 8'h00;
   localparam logic [7:0] RST_CS1_BASE_LOW = 8'h00;
   localparam logic [7:0] RST_CS1_BASE_HIGH = 8'h00;
   localparam logic [7:0] RST_CS0_MASK_CONTROL = 8'h00;
   localparam logic [7:0] RST_CS1_MASK_CONTROL = 8'h7F;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int MASK_XCVR_BIT = 7;
   localparam int MASK_LOW_WIDTH = 7;

   // ****************************************************************
   // Decode patterns
   // ****************************************************************
   localparam logic [7:0] CMOS_RAM_HIGH = 8'h08;
   localparam logic [7:0] KBD_PATTERN = 8'h60;
   localparam logic [7:0] KBD_CARE = 8'hF1;
   localparam logic [7:0] CLOCK_CHIP_PATTERN = 8'h71;
   localparam logic [7:0] CLOCK_CHIP_CARE = 8'hF1;
   localparam logic [7:0] COPROC_PATTERN = 8'hE0;
   localparam logic [7:0] COPROC_CARE = 8'hE8;
   localparam logic [11:0] BUS_CTRL_PATTERN = 12'h0C1;
   localparam logic [7:0] KBD_CTRL_PORT = 8'h64;
   localparam logic [7:0] CPU_RESET_CMD = 8'hF0;
   localparam int SLOT_COUNT = 8;
   localparam int SLOT_BASE_HIGH = 4'h1;

endpackage

/* File: rtl/slot_enable_decode.sv */
/*
 * Slot enable decoder: one enable per expansion slot.
 * Assumes slot-specific I/O space nXXXh with n = slot number (1..N),
 * and that motherboard I/O (high nibble 0) reaches every slot.
 */
module slot_enable_decode #(
   parameter int SLOTS = 8
) (
   input wire logic [15:0] addr,
   input wire logic mem_cycle,
   input wire logic dma_addr_flag,
   output logic [SLOTS-1:0] slot_enable
);

   // ****************************************************************
   // Per-slot decode
   // ****************************************************************
   for (genvar i = 0; i < SLOTS; i++) begin : g_slot
      always_comb begin
         // DMA-driven addresses enable every slot
         if (dma_addr_flag || mem_cycle) begin
            slot_enable[i] = 1'b1;
         end else if (addr[15:12] == 4'h0) begin
            slot_enable[i] = 1'b1;
         end else begin
            slot_enable[i] = (addr[15:12] == 4'(i + 1));
         end
      end
   end

endmodule

/* File: rtl/io_address_decoder.sv */
/*
 * I/O address decoder: slot enables, peripheral chip selects, keyboard and
 * clock-chip strobes, CPU-reset arming and two programmable I/O selects.
 * Assumes all bus inputs are synchronous to sys_clk; strobes are active high
 * inputs here (asserted = command active) and all selects are active high.
 */
// Summary of operation
// - One address enable per slot, eight
// - Latch strobe rising edge captures all selects except clock chip select
// - DMA address flag qualifies slot and decodes
// - CMOS RAM control on 08XXh
// - Keyboard select on 0110 XXX0b
// - Test mode: kbd pin low, test high
// - Keyboard write with I/O write, unless arming
// - Write F0h to port 64h arms reset
// - Coprocessor select on 111X 0XXXb, no DMA
// - Clock chip select on read/write, 0111XXX1b
// - Clock chip rw only on write
// - Bus controller select C10h..C1Fh
// - GP selects decode 1 to 128 bytes
// - Select 0 compares against Cs0_base_low/Cs0_base_high
// - Cs0_mask_control bits 6:0 mask address bits
// - Mask bit 7 enables transceiver, default off
// - Select 0 resets to one byte at 0
// - Select 1 uses Cs1_base_low/Cs1_base_high/Cs1_mask_control, 128 bytes
module io_address_decoder #(
   parameter int SLOTS = io_decode_pkg::SLOT_COUNT
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [15:2] latched_addr,
   input wire logic [6:0] sys_addr_low,
   input wire logic mem_cycle,
   input wire logic io_read_cmd,
   input wire logic io_write_cmd,
   input wire logic dma_addr_flag,
   input wire logic slot_enable_latch,
   input wire logic test_select_pin,
   input wire logic kbd_select_or_test_in,
   input wire logic [7:0] data_in,
   output logic [SLOTS-1:0] slot_enable,
   output logic cmos_ram_control,
   output logic kbd_select_or_test_out,
   output logic kbd_select_or_test_oe,
   output logic kbd_write_strobe,
   output logic coproc_select,
   output logic clock_chip_select,
   output logic clock_chip_rw,
   output logic bus_ctrl_select,
   output logic gp_select_0,
   output logic gp_select_1,
   output logic xbus_xcvr_enable,
   output logic arm_cpu_reset,
   output logic test_mode,
   output logic [7:0] data_out,
   output logic data_out_enable
);

   // ****************************************************************
   // Address assembly and helpers
   // ****************************************************************
   logic [15:0] addr;
   logic [SLOTS-1:0] slot_decode;

   assign addr = {latched_addr[15:7], sys_addr_low};

   function automatic logic gp_hit(input logic [15:0] a, input logic [15:0] base, input logic [7:0] mask);
      logic [6:0] care;
      care = ~mask[io_decode_pkg::MASK_LOW_WIDTH-1:0];
      gp_hit = (a[15:7] == base[15:7]) && (((a[6:0] ^ base[6:0]) & care) == 7'h00);
   endfunction

   function automatic logic byte_match(input logic [7:0] a, input logic [7:0] pat, input logic [7:0] care);
      byte_match = ((a ^ pat) & care) == 8'h00;
   endfunction

   slot_enable_decode #(
      .SLOTS(SLOTS)
   ) u_slot (
      .addr(addr),
      .mem_cycle(mem_cycle),
      .dma_addr_flag(dma_addr_flag),
      .slot_enable(slot_decode)
   );

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   logic [7:0] cs0_base_low, cs0_base_high, cs1_base_low, cs1_base_high;
   logic [7:0] cs0_mask_control, cs1_mask_control;
   logic [7:0] next_cs0_base_low, next_cs0_base_high, next_cs1_base_low, next_cs1_base_high;
   logic [7:0] next_cs0_mask_control, next_cs1_mask_control;
   logic host_write, host_read;

   assign host_write = io_write_cmd && !dma_addr_flag;
   assign host_read = io_read_cmd && !dma_addr_flag;

   always_comb begin
      next_cs0_base_low = cs0_base_low;
      next_cs0_base_high = cs0_base_high;
      next_cs1_base_low = cs1_base_low;
      next_cs1_base_high = cs1_base_high;
      next_cs0_mask_control = cs0_mask_control;
      next_cs1_mask_control = cs1_mask_control;
      if (host_write) begin
         case (addr)
            io_decode_pkg::ADDR_CS0_BASE_LOW: next_cs0_base_low = data_in;
            io_decode_pkg::ADDR_CS0_BASE_HIGH: next_cs0_base_high = data_in;
            io_decode_pkg::ADDR_CS1_BASE_LOW: next_cs1_base_low = data_in;
            io_decode_pkg::ADDR_CS1_BASE_HIGH: next_cs1_base_high = data_in;
            io_decode_pkg::ADDR_CS0_MASK_CONTROL: next_cs0_mask_control = data_in;
            io_decode_pkg::ADDR_CS1_MASK_CONTROL: next_cs1_mask_control = data_in;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cs0_base_low <= io_decode_pkg::RST_CS0_BASE_LOW;
         cs0_base_high <= io_decode_pkg::RST_CS0_BASE_HIGH;
         cs1_base_low <= io_decode_pkg::RST_CS1_BASE_LOW;
         cs1_base_high <= io_decode_pkg::RST_CS1_BASE_HIGH;
         cs0_mask_control <= io_decode_pkg::RST_CS0_MASK_CONTROL;
         cs1_mask_control <= io_decode_pkg::RST_CS1_MASK_CONTROL;
      end else begin
         cs0_base_low <= next_cs0_base_low;
         cs0_base_high <= next_cs0_base_high;
         cs1_base_low <= next_cs1_base_low;
         cs1_base_high <= next_cs1_base_high;
         cs0_mask_control <= next_cs0_mask_control;
         cs1_mask_control <= next_cs1_mask_control;
      end
   end

   // ****************************************************************
   // Combinational decodes
   // ****************************************************************
   logic dec_cmos, dec_kbd, dec_coproc, dec_clock, dec_bus_ctrl, dec_gp0, dec_gp1, dec_xcvr;
   logic dec_arm_write;
   logic [7:0] rd_data;
   logic rd_hit;

   always_comb begin
      dec_cmos = !dma_addr_flag && (addr[15:8] == io_decode_pkg::CMOS_RAM_HIGH);
      dec_kbd = !dma_addr_flag && (addr[15:8] == 8'h00) &&
         byte_match(addr[7:0], io_decode_pkg::KBD_PATTERN, io_decode_pkg::KBD_CARE);
      dec_coproc = !dma_addr_flag && (addr[15:8] == 8'h00) &&
         byte_match(addr[7:0], io_decode_pkg::COPROC_PATTERN, io_decode_pkg::COPROC_CARE);
      dec_clock = !dma_addr_flag && (addr[15:8] == 8'h00) &&
         byte_match(addr[7:0], io_decode_pkg::CLOCK_CHIP_PATTERN, io_decode_pkg::CLOCK_CHIP_CARE);
      dec_bus_ctrl = !dma_addr_flag && (addr[15:4] == io_decode_pkg::BUS_CTRL_PATTERN);
      dec_gp0 = !dma_addr_flag && gp_hit(addr, {cs0_base_high, cs0_base_low}, cs0_mask_control);
      dec_gp1 = !dma_addr_flag && gp_hit(addr, {cs1_base_high, cs1_base_low}, cs1_mask_control);
      dec_xcvr = (dec_gp0 && cs0_mask_control[io_decode_pkg::MASK_XCVR_BIT]) ||
         (dec_gp1 && cs1_mask_control[io_decode_pkg::MASK_XCVR_BIT]);
      dec_arm_write = host_write && (addr == {8'h00, io_decode_pkg::KBD_CTRL_PORT}) &&
         (data_in == io_decode_pkg::CPU_RESET_CMD);
   end

   always_comb begin
      rd_hit = 1'b1;
      case (addr)
         io_decode_pkg::ADDR_CS0_BASE_LOW: rd_data = cs0_base_low;
         io_decode_pkg::ADDR_CS0_BASE_HIGH: rd_data = cs0_base_high;
         io_decode_pkg::ADDR_CS1_BASE_LOW: rd_data = cs1_base_low;
         io_decode_pkg::ADDR_CS1_BASE_HIGH: rd_data = cs1_base_high;
         io_decode_pkg::ADDR_CS0_MASK_CONTROL: rd_data = cs0_mask_control;
         io_decode_pkg::ADDR_CS1_MASK_CONTROL: rd_data = cs1_mask_control;
         default: begin
            rd_data = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Latched chip selects
   // ****************************************************************
   logic latch_prev, latch_rise;
   logic [SLOTS-1:0] next_slot_enable;
   logic next_cmos, next_kbd_sel, next_coproc, next_bus_ctrl, next_gp0, next_gp1, next_xcvr_sel;
   logic kbd_sel, xcvr_sel, clock_sel;

   assign latch_rise = slot_enable_latch && !latch_prev;

   always_comb begin
      next_slot_enable = slot_enable;
      next_cmos = cmos_ram_control;
      next_kbd_sel = kbd_sel;
      next_coproc = coproc_select;
      next_bus_ctrl = bus_ctrl_select;
      next_gp0 = gp_select_0;
      next_gp1 = gp_select_1;
      next_xcvr_sel = xcvr_sel;
      clock_sel = dec_clock;
      if (latch_rise) begin
         next_slot_enable = slot_decode;
         next_cmos = dec_cmos;
         next_kbd_sel = dec_kbd;
         next_coproc = dec_coproc;
         next_bus_ctrl = dec_bus_ctrl;
         next_gp0 = dec_gp0;
         next_gp1 = dec_gp1;
         next_xcvr_sel = dec_xcvr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // Idle level of the strobe is high: no false capture at release
         latch_prev <= 1'b1;
         slot_enable <= '0;
         cmos_ram_control <= 1'b0;
         kbd_sel <= 1'b0;
         coproc_select <= 1'b0;
         bus_ctrl_select <= 1'b0;
         gp_select_0 <= 1'b0;
         gp_select_1 <= 1'b0;
         xcvr_sel <= 1'b0;
      end else begin
         latch_prev <= slot_enable_latch;
         slot_enable <= next_slot_enable;
         cmos_ram_control <= next_cmos;
         kbd_sel <= next_kbd_sel;
         coproc_select <= next_coproc;
         bus_ctrl_select <= next_bus_ctrl;
         gp_select_0 <= next_gp0;
         gp_select_1 <= next_gp1;
         xcvr_sel <= next_xcvr_sel;
      end
   end

   // ****************************************************************
   // Command strobes, reset arming and test mode
   // ****************************************************************
   logic next_kbd_write, next_clock_sel, next_clock_rw, next_arm, next_xcvr;
   logic next_test_mode, next_kbd_out, next_kbd_oe;
   logic [7:0] next_data_out;
   logic next_data_oe;

   always_comb begin
      next_arm = dec_arm_write;
      next_kbd_write = io_write_cmd && !next_arm;
      next_clock_sel = (io_read_cmd || io_write_cmd) && clock_sel;
      next_clock_rw = io_write_cmd && clock_sel;
      next_xcvr = xcvr_sel && (io_read_cmd || io_write_cmd);
      next_test_mode = test_mode;
      if (!rst_n) begin
         next_test_mode = !kbd_select_or_test_in && test_select_pin;
      end
      next_kbd_oe = rst_n && !test_mode;
      next_kbd_out = rst_n ? kbd_sel : 1'b1;
      next_data_out = rd_data;
      next_data_oe = host_read && rd_hit && !test_mode;
   end

   // Test mode is sampled while reset is held; its last value stands at release.
   always_ff @(posedge sys_clk) begin
      test_mode <= next_test_mode;
      if (!rst_n) begin
         kbd_write_strobe <= 1'b0;
         clock_chip_select <= 1'b0;
         clock_chip_rw <= 1'b0;
         arm_cpu_reset <= 1'b0;
         xbus_xcvr_enable <= 1'b0;
         kbd_select_or_test_out <= 1'b1;
         kbd_select_or_test_oe <= 1'b0;
         data_out <= 8'h00;
         data_out_enable <= 1'b0;
      end else begin
         kbd_write_strobe <= next_kbd_write;
         clock_chip_select <= next_clock_sel;
         clock_chip_rw <= next_clock_rw;
         arm_cpu_reset <= next_arm;
         xbus_xcvr_enable <= next_xcvr;
         kbd_select_or_test_out <= next_kbd_out;
         kbd_select_or_test_oe <= next_kbd_oe;
         data_out <= next_data_out;
         data_out_enable <= next_data_oe;
      end
   end

endmodule

/* File: testbench/kbd_pin_model.sv */
/* Keyboard select pin: module drive, outside tester and weak pull-up.
   Assumes the tester only ever pulls the pin low. */
module kbd_pin_model (
   input wire logic dut_out,
   input wire logic dut_oe,
   input wire logic tester_low,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Wire level
   // ****
   always_comb begin
      if (tester_low) begin
         pin = 1'h0;
      end
      else if (dut_oe) begin
         pin = dut_out;
      end
      else begin
         pin = 1'h1;
      end
   end
endmodule

/* File: testbench/io_address_decoder_checker.sv */
/* Port assertions for the I/O address decoder.
   Assumes binding to the decoder top, one clock domain. */
module io_address_decoder_checker #(
   parameter int SLOTS = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [15:2] latched_addr,
   input wire logic io_read_cmd,
   input wire logic io_write_cmd,
   input wire logic dma_addr_flag,
   input wire logic slot_enable_latch,
   input wire logic [7:0] data_in,
   input wire logic [SLOTS-1:0] slot_enable,
   input wire logic cmos_ram_control,
   input wire logic kbd_select_or_test_oe,
   input wire logic kbd_write_strobe,
   input wire logic coproc_select,
   input wire logic clock_chip_select,
   input wire logic clock_chip_rw,
   input wire logic bus_ctrl_select,
   input wire logic gp_select_0,
   input wire logic gp_select_1,
   input wire logic arm_cpu_reset,
   input wire logic test_mode
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ****
   // Assertions
   // ****
   a_kbd_wr_blocked: assert property (arm_cpu_reset |-> !kbd_write_strobe)
      else $error("keyboard write while arming");
   a_kbd_wr_cause: assert property (kbd_write_strobe |-> $past(io_write_cmd))
      else $error("keyboard write without io write");
   a_arm_cause: assert property (arm_cpu_reset |-> $past(io_write_cmd) && $past(data_in) == 8'hf0)
      else $error("arming without reset command");
   a_clock_sel_cmd: assert property (clock_chip_select |-> $past(io_read_cmd || io_write_cmd))
      else $error("clock select without command");
   a_clock_rw_write: assert property (clock_chip_rw |-> clock_chip_select && $past(io_write_cmd))
      else $error("clock rw without write");
   a_sel_latch_hold: assert property ($changed({cmos_ram_control, coproc_select, bus_ctrl_select,
      gp_select_0, gp_select_1, slot_enable}) |-> $past(slot_enable_latch))
      else $error("select changed without latch");
   a_coproc_dma: assert property ($rose(coproc_select) |-> !$past(dma_addr_flag))
      else $error("coprocessor select on dma");
   a_bus_ctrl_addr: assert property ($rose(bus_ctrl_select) |-> $past(latched_addr[15:4]) == 12'h0c1)
      else $error("bus controller select off range");
   a_cmos_addr: assert property ($rose(cmos_ram_control) |-> $past(latched_addr[15:8]) == 8'h08)
      else $error("cmos control off range");
   a_test_float: assert property (test_mode |-> !kbd_select_or_test_oe)
      else $error("keyboard pin driven in test mode");
endmodule

bind io_address_decoder io_address_decoder_checker #(.SLOTS(SLOTS)) i_chk (.sys_clk, .rst_n, .latched_addr,
   .io_read_cmd, .io_write_cmd, .dma_addr_flag, .slot_enable_latch, .data_in, .slot_enable, .cmos_ram_control,
   .kbd_select_or_test_oe, .kbd_write_strobe, .coproc_select, .clock_chip_select, .clock_chip_rw,
   .bus_ctrl_select, .gp_select_0, .gp_select_1, .arm_cpu_reset, .test_mode);

/* File: testbench/io_address_decoder_test.sv */
/* Self-checking bench for the I/O address decoder.
   Assumes package, decoder, pin model and checker compiled first. */
module io_address_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [15:2] latched_addr = 14'h0;
   logic [6:0] sys_addr_low = 7'h0;
   logic [7:0] data_in = 8'h0;
   logic mem_cycle = 1'h0, io_read_cmd = 1'h0, io_write_cmd = 1'h0, dma_addr_flag = 1'h0;
   logic slot_enable_latch = 1'h0, test_select_pin = 1'h0, tester_low = 1'h0, mem_next = 1'h0;
   logic kbd_pin, cmos_ram_control, kbd_select_or_test_out, kbd_select_or_test_oe, kbd_write_strobe;
   logic coproc_select, clock_chip_select, clock_chip_rw, bus_ctrl_select, gp_select_0, gp_select_1;
   logic xbus_xcvr_enable, arm_cpu_reset, test_mode, data_out_enable, prev_oe = 1'h0;
   logic [7:0] slot_enable, data_out, b1, m1;
   logic [7:0] q[$];
   logic [31:0] seed = 32'h0000_12a4;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [13:0] sel_now;
   logic [4:0] stb;
   assign sel_now = {slot_enable, cmos_ram_control, kbd_select_or_test_out, coproc_select, bus_ctrl_select,
                     gp_select_0, gp_select_1};
   assign stb = {kbd_write_strobe, clock_chip_select, clock_chip_rw, arm_cpu_reset, xbus_xcvr_enable};

   always #2.5 sys_clk = ~sys_clk;

   kbd_pin_model i_pin (.dut_out(kbd_select_or_test_out), .dut_oe(kbd_select_or_test_oe),
                        .tester_low(tester_low), .pin(kbd_pin));
   io_address_decoder #(.SLOTS(8)) i_dut (.sys_clk, .rst_n, .latched_addr, .sys_addr_low, .mem_cycle,
      .io_read_cmd, .io_write_cmd, .dma_addr_flag, .slot_enable_latch, .test_select_pin,
      .kbd_select_or_test_in(kbd_pin), .data_in, .slot_enable, .cmos_ram_control, .kbd_select_or_test_out,
      .kbd_select_or_test_oe, .kbd_write_strobe, .coproc_select, .clock_chip_select, .clock_chip_rw,
      .bus_ctrl_select, .gp_select_0, .gp_select_1, .xbus_xcvr_enable, .arm_cpu_reset, .test_mode,
      .data_out, .data_out_enable);

   // ****
   // Reference, stimulus and compares
   // ****
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [13:0] ref_sel(input logic [15:0] a, input logic dm);
      logic z;
      logic [7:0] s;
      z = (a[15:8] == 8'h00) && !dm;
      s = (a[15:12] == 4'h0 || dm) ? 8'hff : 8'h01 << (a[15:12] - 4'h1);
      return {s, a[15:8] == 8'h08 && !dm, z && (a[7:0] & 8'hf1) == 8'h60, z && (a[7:0] & 8'he8) == 8'he0,
              !dm && a[15:4] == 12'h0c1, !dm && a == 16'h0000,
              !dm && a[15:7] == {8'h00, b1[7]} && ((a[6:0] ^ b1[6:0]) & ~m1[6:0]) == 7'h00};
   endfunction

   task automatic check_sel(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] care);
      total_checks++;
      if ((got & care) !== (exp & care)) begin
         n_fail++;
         $display("CHECK FAILED %0t outputs %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic r, input logic w, input logic dm);
      @(posedge sys_clk);
      latched_addr <= a[15:2];
      sys_addr_low <= a[6:0];
      data_in <= d;
      io_read_cmd <= r;
      io_write_cmd <= w;
      dma_addr_flag <= dm;
      mem_cycle <= mem_next;
      slot_enable_latch <= 1'h0;
      @(posedge sys_clk);
      slot_enable_latch <= 1'h1;
      repeat (3) @(posedge sys_clk);
      io_read_cmd <= 1'h0;
      io_write_cmd <= 1'h0;
      @(negedge sys_clk);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      q.push_back(e);
      cyc(a, 8'h00, 1'h1, 1'h0, 1'h0);
   endtask

   task automatic stb_case(input logic [15:0] a, input logic [7:0] d, input logic r, input logic w,
                           input logic [4:0] e, input logic [4:0] c);
      cyc(a, d, r, w, 1'h0);
      check_sel({11'h0, stb}, {11'h0, e}, {11'h0, c});
   endtask

   task automatic do_reset(input logic tl, input logic ts);
      @(posedge sys_clk);
      rst_n <= 1'h0;
      tester_low <= tl;
      test_select_pin <= ts;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'h1;
      tester_low <= 1'h0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic test_done();
      if (n_fail == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end
      else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Read results matched oldest first
   always @(negedge sys_clk) begin
      if (data_out_enable === 1'h1 && prev_oe !== 1'h1 && q.size() > 0) begin
         check_reg(data_out, q.pop_front());
      end
      else if (data_out_enable === 1'h1 && prev_oe !== 1'h1) begin
         n_fail++;
         $display("CHECK FAILED %0t unexpected read data", $time);
      end
      prev_oe = data_out_enable;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         test_done();
      end
   end

   initial begin
      logic [15:0] dir [16] = '{16'h0000, 16'h007f, 16'h0080, 16'h0060, 16'h0061, 16'h006e, 16'h00f3,
         16'h00e8, 16'h00e7, 16'h0871, 16'h0c10, 16'h0c1f, 16'h0c20, 16'h8000, 16'h1234, 16'h00e0};
      logic [7:0] hb [8] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h0c, 8'h10, 8'h50, 8'h90};
      logic [31:0] r, r2;
      logic [15:0] a;
      logic dm;
      b1 = 8'h00;
      m1 = 8'h7f;
      do_reset(1'h0, 1'h0);
      check_sel({14'h0, test_mode, kbd_select_or_test_oe}, 16'h0001, 16'h0003);
      for (int i = 2; i < 8; i++) begin
         rd(16'h0c00 + i, (i == 7) ? 8'h7f : 8'h00);
      end
      for (int i = 0; i < 16; i++) begin
         dm = (i == 15);
         cyc(dir[i], 8'h00, 1'h0, 1'h0, dm);
         check_sel({2'h0, sel_now}, {2'h0, ref_sel(dir[i], dm)}, 16'h3fff);
      end
      mem_next = 1'h1;
      cyc(16'h9000, 8'h00, 1'h0, 1'h0, 1'h0);
      check_sel({8'h00, slot_enable}, 16'h00ff, 16'h00ff);
      mem_next = 1'h0;
      stb_case(16'h0060, 8'h55, 1'h0, 1'h1, 5'h10, 5'h13);
      stb_case(16'h0064, 8'hf0, 1'h0, 1'h1, 5'h02, 5'h13);
      stb_case(16'h0064, 8'h55, 1'h0, 1'h1, 5'h10, 5'h13);
      stb_case(16'h0071, 8'h00, 1'h0, 1'h1, 5'h0c, 5'h0e);
      stb_case(16'h0073, 8'h00, 1'h1, 1'h0, 5'h08, 5'h0e);
      stb_case(16'h0070, 8'h00, 1'h0, 1'h1, 5'h00, 5'h0c);
      stb_case(16'h0000, 8'h00, 1'h1, 1'h0, 5'h00, 5'h01);
      cyc(16'h0c06, 8'h80, 1'h0, 1'h1, 1'h0);
      stb_case(16'h0000, 8'h00, 1'h1, 1'h0, 5'h01, 5'h01);
      for (int i = 0; i < 40; i++) begin
         r = xs();
         r2 = xs();
         b1 = r[7:0];
         m1 = r[15:8];
         cyc(16'h0c04, b1, 1'h0, 1'h1, 1'h0);
         cyc(16'h0c07, m1, 1'h0, 1'h1, 1'h0);
         rd(16'h0c07, m1);
         dm = (r2[23:22] == 2'h0);
         a = {hb[r2[18:16]], r2[21] ? b1 ^ (r2[7:0] & {1'h0, m1[6:0]}) : r2[7:0]};
         cyc(a, 8'h00, 1'h0, 1'h0, dm);
         check_sel({2'h0, sel_now}, {2'h0, ref_sel(a, dm)}, 16'h3fff);
      end
      do_reset(1'h1, 1'h1);
      check_sel({14'h0, test_mode, kbd_select_or_test_oe}, 16'h0002, 16'h0003);
      do_reset(1'h0, 1'h1);
      check_sel({14'h0, test_mode, kbd_select_or_test_oe}, 16'h0001, 16'h0003);
      rd(16'h0c06, 8'h00);
      rd(16'h0c07, 8'h7f);
      if (q.size() != 0) begin
         n_fail++;
         $display("CHECK FAILED %0t read data missing", $time);
      end
      test_done();
   end
endmodule
